// >>> hdl/plc_io_pkg.sv
// constants, codes and register map of the plc slot assignment block
package plc_io_pkg;

  // ----------------------------------------------------------------
  // slot geometry
  // ----------------------------------------------------------------
  localparam int OUT_SLOTS = 6;
  localparam int IN_SLOTS = 3;
  localparam int OSEL_W = 5;              // output function code width
  localparam int ISEL_W = 4;              // input function code width
  localparam int OFN_N = 20;              // number of output functions
  localparam int IFN_N = 10;              // number of input functions
  localparam int OMAP_W = OUT_SLOTS * OSEL_W;
  localparam int IMAP_W = IN_SLOTS * ISEL_W;

  // ----------------------------------------------------------------
  // output function codes
  // ----------------------------------------------------------------
  localparam logic [4:0] OFN_SENSOR_PASS = 5'h00;
  localparam logic [4:0] OFN_PROG_STROBE = 5'h01;
  localparam logic [4:0] OFN_PROG_BIT0 = 5'h02;   // bits 1..3 follow
  localparam logic [4:0] OFN_PROG_BIT1 = 5'h03;
  localparam logic [4:0] OFN_PROG_BIT2 = 5'h04;
  localparam logic [4:0] OFN_MEASURING = 5'h06;
  localparam logic [4:0] OFN_SWITCH_S3 = 5'h07;   // s4..s6 follow
  localparam logic [4:0] OFN_TRIAL = 5'h0B;
  localparam logic [4:0] OFN_ERROR = 5'h0C;
  localparam logic [4:0] OFN_TARE_WARN = 5'h0D;
  localparam logic [4:0] OFN_CONFIG = 5'h0E;
  localparam logic [4:0] OFN_ACK_ALARM = 5'h0F;
  localparam logic [4:0] OFN_ACK_LOCK = 5'h10;
  localparam logic [4:0] OFN_ACK_PASS = 5'h11;
  localparam logic [4:0] OFN_ACK_FAIL = 5'h12;
  localparam logic [4:0] OFN_HOST_LOG = 5'h13;

  // ----------------------------------------------------------------
  // input function codes
  // ----------------------------------------------------------------
  localparam logic [3:0] IFN_TARE_X = 4'h0;
  localparam logic [3:0] IFN_TARE_Y = 4'h1;
  localparam logic [3:0] IFN_TARE_XY = 4'h2;
  localparam logic [3:0] IFN_CLR_STAT = 4'h3;
  localparam logic [3:0] IFN_SENSOR = 4'h4;
  localparam logic [3:0] IFN_TRIAL = 4'h5;
  localparam logic [3:0] IFN_ACK_BOTH = 4'h6;
  localparam logic [3:0] IFN_ACK_PASS = 4'h7;
  localparam logic [3:0] IFN_ACK_FAIL = 4'h8;
  localparam logic [3:0] IFN_ACK_ERR = 4'h9;

  // ----------------------------------------------------------------
  // factory default maps, slot 1 in the low bits
  // ----------------------------------------------------------------
  localparam logic [OMAP_W-1:0] OMAP_RST = {OFN_MEASURING, OFN_PROG_BIT2,
    OFN_PROG_BIT1, OFN_PROG_BIT0, OFN_PROG_STROBE, OFN_SENSOR_PASS};
  localparam logic [IMAP_W-1:0] IMAP_RST = {IFN_SENSOR, IFN_CLR_STAT, IFN_TARE_X};

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OMAP = 8'h04;
  localparam logic [7:0] ADDR_IMAP = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  localparam int CTRL_SRC = 0;            // 1: fieldbus controls
  localparam int CTRL_RESTORE = 1;        // write one: defaults
  localparam int CTRL_CFG = 2;            // configuration mode
  localparam int CTRL_LOG = 3;            // host logging enabled
  localparam int IRQ_W = 4;
  localparam int IRQ_ERR = 0;
  localparam int IRQ_MEAS_END = 1;
  localparam int IRQ_MAP_DONE = 2;
  localparam int IRQ_EVAL = 3;

  // ----------------------------------------------------------------
  // map update sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {UPD_IDLE, UPD_BLANK, UPD_APPLY} upd_state_t;

endpackage

// >>> hdl/slot_if.sv
// carrier between the slot controller and the output slot mux
interface slot_if;
  import plc_io_pkg::*;
  logic [OMAP_W-1:0] sel;        // active output map
  logic [OFN_N-1:0] fn;          // current function levels
  logic [OUT_SLOTS-1:0] blank;   // slots forced low
  logic [OUT_SLOTS-1:0] slot_q;  // registered slot levels
  modport ctrl (output sel, output fn, output blank, input slot_q);
  modport mux (input sel, input fn, input blank, output slot_q);
endinterface

// >>> hdl/pin_sync.sv
// two flip-flop synchroniser for the discrete plc inputs
module pin_sync #(
  parameter int W = 3
) (
  input wire logic i_clk,           // system clock
  input wire logic i_rst,           // async reset, high
  input wire logic [W-1:0] i_d,     // asynchronous pins
  output logic [W-1:0] o_q          // synchronised levels
);

  logic [W-1:0] meta_ff;            // first stage, read by o_q only

  // ----------------------------------------------------------------
  // two stages against metastability
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= '0;
      o_q <= '0;
    end else begin
      meta_ff <= i_d;
      o_q <= meta_ff;
    end
  end

endmodule // pin_sync

// >>> hdl/out_slot_mux.sv
// per-slot function selection for the six assignable outputs
module out_slot_mux import plc_io_pkg::*; (
  input wire logic i_clk,   // system clock
  input wire logic i_rst,   // async reset, high
  slot_if.mux bus           // map, levels and slot outputs
);

  // pick one function level; unknown codes give a low output
  function automatic logic pick(input logic [OSEL_W-1:0] c,
                                input logic [OFN_N-1:0] f);
    pick = (c < OFN_N) ? f[c] : 1'b0;
  endfunction

  // ----------------------------------------------------------------
  // registered slot levels, blanked slots held low
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.slot_q <= '0;
    end else begin
      for (int s = 0; s < OUT_SLOTS; s++) begin
        bus.slot_q[s] <= bus.blank[s] ? 1'b0 : pick(bus.sel[s*OSEL_W +: OSEL_W], bus.fn);
      end
    end
  end

endmodule // out_slot_mux

// >>> hdl/plc_io_signal_assignment.sv
// top level: slot assignment of plc and fieldbus control signals
//
// Our own choices: register access over APB and the address map.
module plc_io_signal_assignment import plc_io_pkg::*; (
  input wire logic I_CLK,                 // system clock 100 mhz
  input wire logic I_RST,                 // async reset, high
  input wire logic I_PSEL,                // apb select
  input wire logic I_PENABLE,             // apb access phase
  input wire logic I_PWRITE,              // apb write
  input wire logic [7:0] I_PADDR,         // apb byte address
  input wire logic [31:0] I_PWDATA,       // apb write data
  output logic [31:0] O_PRDATA,           // apb read data
  output logic O_PREADY,                  // apb ready
  output logic O_PSLVERR,                 // apb error
  input wire logic [IN_SLOTS-1:0] I_PLC_IN,   // discrete inputs, async
  input wire logic [IN_SLOTS-1:0] I_FB_IN,    // fieldbus control bits
  input wire logic I_MEAS_BUSY,           // measurement in progress
  input wire logic I_MEAS_START,          // start pulse
  input wire logic I_READY,               // ready status
  input wire logic I_OVERDRIVE,           // channel overdriven
  input wire logic I_BOOT_ERR,            // boot-up device fault
  input wire logic I_ERR_PERM,            // fault is permanent
  input wire logic I_SENSOR_PASS,         // sensor test passed
  input wire logic [3:0] I_PROG_NUM,      // selected program
  input wire logic I_PROG_VALID,          // program number valid
  input wire logic [3:0] I_SWITCH,        // switch signals s3..s6
  input wire logic I_TARE_LIMIT,          // tare limit reached
  input wire logic I_EVAL_DONE,           // evaluation pulse
  input wire logic I_EVAL_OK,             // evaluation result
  output logic [OUT_SLOTS-1:0] O_PLC_OUT, // discrete outputs
  output logic [OUT_SLOTS-1:0] O_FB_OUT,  // fieldbus status bits
  output logic O_TARE_X,                  // tare x pulse
  output logic O_TARE_Y,                  // tare y pulse
  output logic O_CLR_STAT,                // clear statistics pulse
  output logic O_SENSOR_CHECK,            // sensor check pulse
  output logic O_TRIAL_MODE,              // trial mode level
  output logic O_IRQ                      // interrupt level
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  slot_if sif ();                          // carrier to slot mux
  logic [IN_SLOTS-1:0] plc_sync;           // synchronised pins
  logic [IN_SLOTS-1:0] src_lvl;            // selected source
  logic [IFN_N-1:0] fn_lvl;                // input function levels
  logic [IFN_N-1:0] fn_prev_ff;            // previous levels
  logic [IFN_N-1:0] fn_rise;               // rising edges
  logic [OMAP_W-1:0] omap_ff;              // active output map
  logic [OMAP_W-1:0] omap_sh_ff;           // software output map
  logic [IMAP_W-1:0] imap_ff;              // active input map
  logic [IMAP_W-1:0] imap_sh_ff;           // software input map
  logic pend_ff;                           // map change waiting
  upd_state_t upd_ff;                      // update sequencer
  upd_state_t nxt_upd;
  logic src_ff;                            // control source
  logic cfg_ff;                            // configuration mode
  logic log_ff;                            // host logging on
  logic err_ff;                            // error output state
  logic err_set;
  logic err_clr;
  logic pass_ff;                           // unacked pass
  logic fail_ff;                           // unacked fail
  logic trial_ff;                          // trial mode
  logic busy_prev_ff;                      // for measurement end
  logic [IRQ_W-1:0] irq_ff;                // sticky events
  logic [IRQ_W-1:0] mask_ff;               // interrupt enables
  logic [IRQ_W-1:0] irq_ev;
  logic wr;                                // apb write strobe
  logic rd_setup;                          // apb read setup
  logic known;                             // address decoded
  logic restore;                           // restore defaults
  logic map_wr;                            // any map write

  // an input function is active if any slot mapped to it is high
  function automatic logic in_hit(input logic [IMAP_W-1:0] m,
                                  input logic [IN_SLOTS-1:0] l,
                                  input logic [ISEL_W-1:0] c);
    in_hit = 1'b0;
    for (int s = 0; s < IN_SLOTS; s++) begin
      if (l[s] && m[s*ISEL_W +: ISEL_W] == c) begin
        in_hit = 1'b1;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // input path
  // ----------------------------------------------------------------
  pin_sync #(.W(IN_SLOTS)) u_sync (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_d(I_PLC_IN),
    .o_q(plc_sync)
  );

  // unselected source is ignored entirely
  assign src_lvl = src_ff ? I_FB_IN : plc_sync;

  // decode through the shared map, same for both sources
  always_comb begin
    for (int f = 0; f < IFN_N; f++) begin
      fn_lvl[f] = in_hit(imap_ff, src_lvl, ISEL_W'(f));
    end
  end

  assign fn_rise = fn_lvl & ~fn_prev_ff;

  // edge memory for the pulse functions
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      fn_prev_ff <= '0;
    end else begin
      fn_prev_ff <= fn_lvl;
    end
  end

  // ----------------------------------------------------------------
  // requests to the instrument
  // ----------------------------------------------------------------
  // one pulse per rising edge; a held input does not repeat
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_TARE_X <= 1'b0;
      O_TARE_Y <= 1'b0;
      O_CLR_STAT <= 1'b0;
      O_SENSOR_CHECK <= 1'b0;
    end else begin
      O_TARE_X <= fn_rise[IFN_TARE_X] | fn_rise[IFN_TARE_XY];
      O_TARE_Y <= fn_rise[IFN_TARE_Y] | fn_rise[IFN_TARE_XY];
      O_CLR_STAT <= fn_rise[IFN_CLR_STAT];
      O_SENSOR_CHECK <= fn_rise[IFN_SENSOR];
    end
  end

  // trial mode held while its input is high
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      trial_ff <= 1'b0;
    end else begin
      trial_ff <= fn_lvl[IFN_TRIAL];
    end
  end

  assign O_TRIAL_MODE = trial_ff;

  // ----------------------------------------------------------------
  // error flag
  // ----------------------------------------------------------------
  assign err_set = (I_MEAS_START & ~I_READY) | I_OVERDRIVE | I_BOOT_ERR;
  // permanent faults survive the acknowledge
  assign err_clr = fn_rise[IFN_ACK_ERR] & err_ff & ~I_ERR_PERM;

  // new fault in the acknowledge cycle wins
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      err_ff <= 1'b0;
    end else begin
      err_ff <= err_set | (err_ff & ~err_clr);
    end
  end

  // ----------------------------------------------------------------
  // acknowledge function
  // ----------------------------------------------------------------
  // a result stays pending until the controller acknowledges it
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pass_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else begin
      if (I_EVAL_DONE && I_EVAL_OK) begin
        pass_ff <= 1'b1;
      end else if (fn_rise[IFN_ACK_BOTH] || fn_rise[IFN_ACK_PASS]) begin
        pass_ff <= 1'b0;
      end
      if (I_EVAL_DONE && !I_EVAL_OK) begin
        fail_ff <= 1'b1;
      end else if (fn_rise[IFN_ACK_BOTH] || fn_rise[IFN_ACK_FAIL]) begin
        fail_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // output function levels
  // ----------------------------------------------------------------
  always_comb begin
    sif.fn = '0;
    sif.fn[OFN_SENSOR_PASS] = I_SENSOR_PASS;
    sif.fn[OFN_PROG_STROBE] = I_PROG_VALID;
    sif.fn[OFN_PROG_BIT0 +: 4] = I_PROG_NUM;
    sif.fn[OFN_MEASURING] = I_MEAS_BUSY;
    sif.fn[OFN_SWITCH_S3 +: 4] = I_SWITCH;
    sif.fn[OFN_TRIAL] = trial_ff;
    sif.fn[OFN_ERROR] = err_ff;
    sif.fn[OFN_TARE_WARN] = I_TARE_LIMIT;
    sif.fn[OFN_CONFIG] = cfg_ff;
    sif.fn[OFN_ACK_ALARM] = fail_ff;
    sif.fn[OFN_ACK_LOCK] = pass_ff | fail_ff;
    sif.fn[OFN_ACK_PASS] = pass_ff;
    sif.fn[OFN_ACK_FAIL] = fail_ff;
    sif.fn[OFN_HOST_LOG] = log_ff;
  end

  // ----------------------------------------------------------------
  // output path
  // ----------------------------------------------------------------
  assign sif.sel = omap_ff;

  // only slots whose assignment changes go low during an update
  always_comb begin
    for (int s = 0; s < OUT_SLOTS; s++) begin
      sif.blank[s] = (upd_ff != UPD_IDLE) &&
        (omap_ff[s*OSEL_W +: OSEL_W] != omap_sh_ff[s*OSEL_W +: OSEL_W]);
    end
  end

  out_slot_mux u_mux (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .bus(sif.mux)
  );

  // one register feeds both paths, so they never disagree
  assign O_PLC_OUT = sif.slot_q;
  assign O_FB_OUT = sif.slot_q;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign wr = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;
  assign known = (I_PADDR == ADDR_CTRL) || (I_PADDR == ADDR_OMAP) ||
    (I_PADDR == ADDR_IMAP) || (I_PADDR == ADDR_STAT) ||
    (I_PADDR == ADDR_IRQ) || (I_PADDR == ADDR_MASK);
  assign O_PREADY = 1'b1;  // no wait states
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~known;
  assign restore = wr && (I_PADDR == ADDR_CTRL) && I_PWDATA[CTRL_RESTORE];
  assign map_wr = wr && ((I_PADDR == ADDR_OMAP) || (I_PADDR == ADDR_IMAP));

  // read data captured in the setup cycle, stable in the access
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PRDATA <= '0;
    end else if (rd_setup) begin
      case (I_PADDR)
        ADDR_CTRL: O_PRDATA <= 32'({log_ff, cfg_ff, 1'b0, src_ff});
        ADDR_OMAP: O_PRDATA <= 32'(omap_sh_ff);
        ADDR_IMAP: O_PRDATA <= 32'(imap_sh_ff);
        ADDR_STAT: O_PRDATA <= {13'h0, src_lvl, 2'h0, sif.slot_q,
          2'h0, pend_ff, fail_ff, pass_ff, trial_ff, err_ff, I_MEAS_BUSY};
        ADDR_IRQ: O_PRDATA <= 32'(irq_ff);
        ADDR_MASK: O_PRDATA <= 32'(mask_ff);
        default: O_PRDATA <= 32'h00000000;  // unmapped reads zero
      endcase
    end
  end

  // control bits
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      src_ff <= 1'b0;
      cfg_ff <= 1'b0;
      log_ff <= 1'b0;
    end else if (wr && I_PADDR == ADDR_CTRL) begin
      src_ff <= I_PWDATA[CTRL_SRC];
      cfg_ff <= I_PWDATA[CTRL_CFG];
      log_ff <= I_PWDATA[CTRL_LOG];
    end
  end

  // ----------------------------------------------------------------
  // software side maps
  // ----------------------------------------------------------------
  // restore wins over a map write in the same access
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      omap_sh_ff <= OMAP_RST;
      imap_sh_ff <= IMAP_RST;
    end else if (restore) begin
      omap_sh_ff <= OMAP_RST;
      imap_sh_ff <= IMAP_RST;
    end else if (wr && I_PADDR == ADDR_OMAP) begin
      omap_sh_ff <= I_PWDATA[OMAP_W-1:0];
    end else if (wr && I_PADDR == ADDR_IMAP) begin
      imap_sh_ff <= I_PWDATA[IMAP_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // map update sequencer
  // ----------------------------------------------------------------
  // waits for a gap between measurements, blanks, then copies
  always_comb begin
    case (upd_ff)
      UPD_IDLE: nxt_upd = (pend_ff && !I_MEAS_BUSY) ? UPD_BLANK : UPD_IDLE;
      UPD_BLANK: nxt_upd = UPD_APPLY;
      UPD_APPLY: nxt_upd = UPD_IDLE;
      default: nxt_upd = UPD_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      upd_ff <= UPD_IDLE;
    end else begin
      upd_ff <= nxt_upd;
    end
  end

  // a write during the copy keeps the request alive
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pend_ff <= 1'b0;
    end else if (map_wr || restore) begin
      pend_ff <= 1'b1;
    end else if (upd_ff == UPD_APPLY) begin
      pend_ff <= 1'b0;
    end
  end

  // active maps change only in the copy cycle
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      omap_ff <= OMAP_RST;
      imap_ff <= IMAP_RST;
    end else if (upd_ff == UPD_APPLY) begin
      omap_ff <= omap_sh_ff;
      imap_ff <= imap_sh_ff;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      busy_prev_ff <= 1'b0;
    end else begin
      busy_prev_ff <= I_MEAS_BUSY;
    end
  end

  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_ERR] = err_set & ~err_ff;
    irq_ev[IRQ_MEAS_END] = busy_prev_ff & ~I_MEAS_BUSY;
    irq_ev[IRQ_MAP_DONE] = (upd_ff == UPD_APPLY);
    irq_ev[IRQ_EVAL] = I_EVAL_DONE;
  end

  // write one to clear; an event in the same cycle stays set
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      irq_ff <= '0;
    end else if (wr && I_PADDR == ADDR_IRQ) begin
      irq_ff <= (irq_ff & ~I_PWDATA[IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_ff <= irq_ff | irq_ev;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      mask_ff <= '0;
    end else if (wr && I_PADDR == ADDR_MASK) begin
      mask_ff <= I_PWDATA[IRQ_W-1:0];
    end
  end

  assign O_IRQ = |(irq_ff & mask_ff);

endmodule // plc_io_signal_assignment

// >>> sim/plc_io_signal_assignment_assertions.sv
// checker on the top ports of the plc slot assignment block
module plc_io_signal_assignment_assertions import plc_io_pkg::*; (
  input wire logic I_CLK, // system clock
  input wire logic I_RST, // async reset, high
  input wire logic I_PSEL, // apb select
  input wire logic I_PENABLE, // apb access phase
  input wire logic I_PWRITE, // apb write
  input wire logic [7:0] I_PADDR, // apb byte address
  input wire logic [31:0] O_PRDATA, // apb read data
  input wire logic O_PSLVERR, // apb error
  input wire logic [OUT_SLOTS-1:0] O_PLC_OUT, // discrete outputs
  input wire logic [OUT_SLOTS-1:0] O_FB_OUT, // fieldbus status bits
  input wire logic O_TARE_X // tare x pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // ------------------------------------------------------------
  // bus answers and slot outputs
  // ------------------------------------------------------------
  sequence s_acc; I_PSEL && I_PENABLE; endsequence
  sequence s_bad; s_acc ##0 I_PADDR > 8'h14; endsequence
  property p_slv; s_bad |-> O_PSLVERR; endproperty
  a_slv: assert property (p_slv) else $error("no error on unmapped access");
  property p_rd0; s_bad ##0 !I_PWRITE |-> O_PRDATA == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
  property p_ok; s_acc ##0 I_PADDR <= 8'h14 ##0 I_PADDR[1:0] == 2'h0 |-> !O_PSLVERR; endproperty
  a_ok: assert property (p_ok) else $error("error on mapped access");
  property p_idle; !(I_PSEL && I_PENABLE) |-> !O_PSLVERR; endproperty
  a_idle: assert property (p_idle) else $error("error outside access phase");
  // read data only moves at a setup edge, so idle reads stay put
  property p_hold; !(I_PSEL && !I_PENABLE) |=> $stable(O_PRDATA); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without setup");
  property p_both; O_FB_OUT == O_PLC_OUT; endproperty
  a_both: assert property (p_both) else $error("fieldbus and discrete outputs differ");
  property p_pulse; O_TARE_X |=> !O_TARE_X; endproperty
  a_pulse: assert property (p_pulse) else $error("tare pulse longer than one cycle");
  property p_rst; disable iff (1'b0) I_RST |-> O_PLC_OUT == 6'h00 && !O_TARE_X && O_PRDATA == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not low in reset");
endmodule // plc_io_signal_assignment_assertions

// >>> sim/plc_partner.sv
// behavioural controller driving the discrete input pins
module plc_partner (
  input wire logic i_clk, // system clock
  input wire logic i_auto, // acknowledge errors unprompted
  input wire logic i_err, // error as seen on output slot 1
  input wire logic [1:0] i_lvl, // levels for input slots 1 and 2
  output logic [2:0] o_pin // discrete input pins, slot 3 acks
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_ff = 3'h0; // ack pulse of four cycles, then a gap
  // ack only while the error shows, and retry after a gap
  always_ff @(posedge i_clk) begin
    if (i_auto && i_err === 1'b1 && cnt_ff == 3'h0) cnt_ff <= 3'h5;
    else if (cnt_ff != 3'h0) cnt_ff <= cnt_ff - 3'h1;
  end
  assign o_pin = {cnt_ff > 3'h1, i_lvl};
endmodule // plc_partner

// >>> sim/plc_io_signal_assignment_test.sv
// self-checking bench for the plc slot assignment block
module plc_io_signal_assignment_test import plc_io_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_CLK = 0, I_RST = 0, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0, I_MEAS_BUSY = 0, I_MEAS_START = 0;
  logic I_READY = 1, I_OVERDRIVE = 0, I_BOOT_ERR = 0, I_ERR_PERM = 0, I_SENSOR_PASS = 0, I_PROG_VALID = 0;
  logic I_TARE_LIMIT = 0, I_EVAL_DONE = 0, I_EVAL_OK = 0, auto = 0; // auto: partner acks errors
  logic [7:0] I_PADDR = 8'h00; // apb address
  logic [31:0] I_PWDATA = 32'h0, O_PRDATA, q; // q: last word read
  logic [2:0] I_PLC_IN, I_FB_IN = 3'h0; // partner pins, fieldbus bits
  logic [3:0] I_PROG_NUM = 4'h0, I_SWITCH = 4'h0;
  logic [1:0] lvl = 2'h0; // partner levels on slots 1 and 2
  logic [OUT_SLOTS-1:0] O_PLC_OUT, O_FB_OUT;
  logic O_PREADY, O_PSLVERR, O_TARE_X, O_TARE_Y, O_CLR_STAT, O_SENSOR_CHECK, O_TRIAL_MODE, O_IRQ;
  int n_mismatch = 0, num_checks = 0, n_tx = 0, n_ty = 0, n_cs = 0, n_sc = 0; // pulse counts per request
  always #5 I_CLK = ~I_CLK; // 100 mhz
  // pulses last one cycle, so counting them at the edge is exact
  always @(posedge I_CLK) if (O_TARE_X === 1'b1) n_tx++;
  always @(posedge I_CLK) if (O_TARE_Y === 1'b1) n_ty++;
  always @(posedge I_CLK) if (O_CLR_STAT === 1'b1) n_cs++;
  always @(posedge I_CLK) if (O_SENSOR_CHECK === 1'b1) n_sc++;
  plc_io_signal_assignment dut (.*);
  plc_partner plc (.i_clk(I_CLK), .i_auto(auto), .i_err(O_PLC_OUT[0]), .i_lvl(lvl), .o_pin(I_PLC_IN));
  task tick(input int n);
    repeat (n) @(posedge I_CLK);
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) $display("Error %s exp %h got %h", s, e, g);
    if (g !== e) n_mismatch++;
  endtask
  task close_out(input int hung);
    n_mismatch += hung;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // apb cycle: setup, access held until pready, one idle edge after
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    {I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} <= {2'b10, w, a, d};
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    for (k = 0; k == 0 || (O_PREADY !== 1'b1 && k < 50); k++) @(posedge I_CLK);
    if (k >= 50) close_out(1);
    q = O_PRDATA;
    {I_PSEL, I_PENABLE} <= 2'b00;
    @(posedge I_CLK);
  endtask
  task rd(input string s, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask
  initial begin
    I_RST <= 1'b1; // rising edge at time zero fires the async reset
    tick(20);
    I_RST <= 1'b0;
    tick(1);
    rd("omap", ADDR_OMAP, {2'h0, OMAP_RST});
    rd("imap", ADDR_IMAP, {20'h0, IMAP_RST});
    rd("hole", 8'h20, 32'h0);
    {I_SENSOR_PASS, I_PROG_VALID, I_PROG_NUM, I_MEAS_BUSY} <= {2'b11, 4'h5, 1'b1};
    tick(3);
    chk("plc out", 32'h37, {26'h0, O_PLC_OUT});
    chk("fb out", 32'h37, {26'h0, O_FB_OUT});
    $display("end defaults");
    I_MEAS_BUSY <= 1'b0;
    xfer(1'b1, ADDR_OMAP, {2'h0, OMAP_RST[OMAP_W-1:5], OFN_ERROR});
    xfer(1'b1, ADDR_IMAP, {20'h0, IFN_ACK_ERR, IFN_TRIAL, IFN_TARE_X});
    {I_READY, I_MEAS_START} <= 2'b01;
    tick(1);
    I_MEAS_START <= 1'b0;
    tick(6);
    chk("err set", 32'h1, {31'h0, O_PLC_OUT[0]});
    auto <= 1'b1;
    tick(16);
    chk("err ack", 32'h0, {31'h0, O_PLC_OUT[0]});
    {I_ERR_PERM, I_OVERDRIVE} <= 2'b11;
    tick(1);
    I_OVERDRIVE <= 1'b0;
    tick(24);
    chk("err perm", 32'h1, {31'h0, O_PLC_OUT[0]});
    xfer(1'b1, ADDR_MASK, 32'h1);
    chk("irq on", 32'h1, {31'h0, O_IRQ});
    xfer(1'b1, ADDR_MASK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, O_IRQ});
    xfer(1'b1, ADDR_IRQ, 32'hF);
    xfer(1'b1, ADDR_MASK, 32'h1);
    chk("irq clear", 32'h0, {31'h0, O_IRQ});
    $display("end error");
    xfer(1'b1, ADDR_CTRL, 32'h1);
    {auto, lvl} <= 3'h1; // partner stops acking, slot 1 pin high
    tick(8);
    I_FB_IN <= 3'h3;
    tick(6);
    chk("fb tare", 32'h1, n_tx);
    chk("trial", 32'h1, {31'h0, O_TRIAL_MODE});
    I_FB_IN <= 3'h0; // drop fieldbus first, so the switch back gives a fresh edge
    xfer(1'b1, ADDR_CTRL, 32'h0);
    tick(8);
    chk("plc tare", 32'h2, n_tx);
    $display("end source");
    xfer(1'b1, ADDR_CTRL, 32'h2);
    rd("omap back", ADDR_OMAP, {2'h0, OMAP_RST});
    rd("imap back", ADDR_IMAP, {20'h0, IMAP_RST});
    $display("end restore");
    xfer(1'b1, ADDR_CTRL, 32'h1);
    xfer(1'b1, ADDR_IMAP, {20'h0, IFN_SENSOR, IFN_CLR_STAT, IFN_TARE_Y});
    tick(3);
    I_FB_IN <= 3'h7;
    tick(6);
    chk("pulses", 32'h02010101, {n_tx[7:0], n_ty[7:0], n_cs[7:0], n_sc[7:0]});
    $display("end pulses");
    close_out(0);
  end
endmodule // plc_io_signal_assignment_test
bind plc_io_signal_assignment plc_io_signal_assignment_assertions u_chk (.*);
